// *** hw/gdc_pkg.sv ***
// package of constants for the gate driver enable and fault control block
// assumes a single 50 MHz clock and an AXI4-Lite register master
package gdc_pkg;
	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_NS       = 20;
	localparam int FILT_NS      = 4000;
	localparam int FILT_CYC     = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int LINK_BIT_NS  = 50000;
	localparam int LINK_BIT_CYC = LINK_BIT_NS / CLK_NS;
	// ****************************************************
	// register map and fields
	// ****************************************************
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
	localparam logic [7:0] DEAD_RST     = 8'h10;
	localparam int         DET_EN_BIT   = 8;
	localparam int         SLEEP_BIT    = 9;
	localparam int         ST_W         = 5;
	localparam int         ST_FAULT     = 0;
	localparam int         ST_ARMED     = 1;
	localparam int         ST_SLEEP     = 2;
	localparam int         ST_RACE      = 3;
	localparam int         ST_SENT      = 4;
	localparam int         IRQ_W        = 5;
	localparam int         IRQ_FAULT    = 0;
	localparam int         IRQ_WAKE     = 1;
	localparam int         IRQ_READY    = 2;
	localparam int         IRQ_RACE     = 3;
	localparam int         IRQ_SENT     = 4;
	localparam logic [1:0] RESP_OKAY    = 2'b00;
	localparam logic [1:0] RESP_SLVERR  = 2'b10;
	// ****************************************************
	// link report frame
	// ****************************************************
	localparam int FRAME_W = 10;
	localparam int RPT_BROWNOUT_WARNING_FLAG = 0;
	localparam int RPT_FAULT = 1;
	typedef enum logic {LK_IDLE, LK_SEND} gdc_link_e;
endpackage : gdc_pkg

// *** hw/gdc_deadtime.sv ***
// dead-time shaper for one half-bridge phase
// assumes pwm inputs synchronous to mclk_i
`timescale 1ns/1ns
module gdc_deadtime
	import gdc_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       drive_en_i,
	input  wire logic [7:0] dead_i,
	// pwm in (bit 1 high side, bit 0 low side)
	input  wire logic [1:0] pwm_i,
	// gate out
	output logic      [1:0] gate_o,
	output logic            race_o
);
	logic [7:0] cnt [2];
	logic [1:0] hit;
	logic       lock;

	// ****************************************************
	// per-side high-time counter and output
	// ****************************************************
	for (genvar i = 0; i < 2; i++) begin : g_side
		assign hit[i] = !pwm_i[i] && (cnt[i] == dead_i) && (dead_i != 8'h00);
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				cnt[i] <= 8'h00;
			end else if (!pwm_i[i]) begin
				cnt[i] <= 8'h00;
			end else if (cnt[i] != 8'hFF) begin
				cnt[i] <= cnt[i] + 8'h01;
			end
		end
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				gate_o[i] <= 1'b0;
			end else begin
				gate_o[i] <= drive_en_i && !lock && !(|hit)
					&& pwm_i[i] && (cnt[i] >= dead_i);
			end
		end
	end

	// ****************************************************
	// equal-width race lock
	// ****************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			lock <= 1'b0;
		end else if (|hit) begin
			lock <= 1'b1;
		end else if (pwm_i == 2'b00) begin
			lock <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			race_o <= 1'b0;
		end else begin
			race_o <= |hit;
		end
	end
endmodule : gdc_deadtime

// *** hw/gdc_top.sv ***
// gate driver enable, fault, dead-time, start-up report and sleep control
// assumes pins synchronous to mclk_i and an AXI4-Lite master
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module gdc_top
	import gdc_pkg::*;
(
	// clock and reset
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	// driver pins
	input  wire logic              enable_i,
	input  wire logic [2:0]        pwm_hi_i,
	input  wire logic [2:0]        pwm_lo_i,
	input  wire logic              boot_ready_i,
	input  wire logic              fault_event_i,
	input  wire logic              lin_activity_i,
	output logic      [2:0]        gate_hi_o,
	output logic      [2:0]        gate_lo_o,
	output logic                   fault_o,
	output logic                   asleep_o,
	// host link pin
	input  wire logic              host_link_pin_i,
	output logic                   host_link_pin_o,
	output logic                   host_link_pin_oe_n_o,
	// interrupt
	output logic                   irq_o
);
	logic [7:0]         dead;
	logic               det_en;
	logic [IRQ_W-1:0]   irq_stat;
	logic [IRQ_W-1:0]   irq_mask;
	logic [IRQ_W-1:0]   irq_ev;
	logic [ADDR_W-1:0]  aw_addr;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               do_wr;
	logic               rd_take;
	logic               en_q;
	logic               lin_q;
	logic               link_q;
	logic               en_filt;
	logic [7:0]         low_cnt;
	logic               filt_clr;
	logic               boot_seen;
	logic               drive_en;
	logic               sleep_cmd;
	logic               wake;
	logic               sent;
	logic               link_go;
	gdc_link_e          link_st;
	logic [FRAME_W-1:0] frame;
	logic [3:0]         bit_idx;
	logic [11:0]        bit_cnt;
	logic [2:0]         race;
	logic [ST_W-1:0]    status;

	// ****************************************************
	// pin edge history
	// ****************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			en_q   <= 1'b0;
			lin_q  <= 1'b0;
			link_q <= 1'b1;
		end else begin
			en_q   <= enable_i;
			lin_q  <= lin_activity_i;
			link_q <= host_link_pin_i;
		end
	end

	// ****************************************************
	// enable low-pulse filter
	// ****************************************************
	assign filt_clr = !enable_i && (low_cnt == 8'(FILT_CYC - 1));

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			low_cnt <= 8'h00;
		end else if (enable_i) begin
			low_cnt <= 8'h00;
		end else if (low_cnt != 8'(FILT_CYC)) begin
			low_cnt <= low_cnt + 8'h01;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			en_filt <= 1'b0;
		end else if (enable_i) begin
			en_filt <= 1'b1;
		end else if (filt_clr) begin
			en_filt <= 1'b0;
		end
	end

	// ****************************************************
	// bootstrap ready gate and fault latch
	// ****************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			boot_seen <= 1'b0;
		end else if (!en_filt) begin
			boot_seen <= 1'b0;
		end else if (boot_ready_i) begin
			boot_seen <= 1'b1;
		end
	end

	assign drive_en = boot_seen && !fault_o && !asleep_o;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			fault_o <= 1'b0;
		end else if (boot_seen && det_en && fault_event_i) begin
			fault_o <= 1'b1;
		end else if (filt_clr) begin
			fault_o <= 1'b0;
		end
	end

	// ****************************************************
	// sleep and wake
	// ****************************************************
	assign wake = (enable_i != en_q) || (lin_activity_i != lin_q);
	assign sleep_cmd = do_wr && (aw_addr == ADDR_CTRL) && w_strb[1]
		&& w_data[SLEEP_BIT];

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			asleep_o <= 1'b0;
		end else if (asleep_o && wake) begin
			asleep_o <= 1'b0;
		end else if (sleep_cmd) begin
			asleep_o <= 1'b1;
		end
	end

	// ****************************************************
	// dead-time shapers, one per phase
	// ****************************************************
	for (genvar p = 0; p < 3; p++) begin : g_phase
		gdc_deadtime u_dt (
			.mclk_i     (mclk_i),
			.rst_i      (rst_i),
			.drive_en_i (drive_en),
			.dead_i     (dead),
			.pwm_i      ({pwm_hi_i[p], pwm_lo_i[p]}),
			.gate_o     ({gate_hi_o[p], gate_lo_o[p]}),
			.race_o     (race[p])
		);
	end

	// ****************************************************
	// one-time start-up report on the host link
	// ****************************************************
	assign link_go = !sent && (link_st == LK_IDLE)
		&& ((enable_i && !en_q) || (!host_link_pin_i && link_q));

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sent    <= 1'b0;
			link_st <= LK_IDLE;
			frame   <= '1;
			bit_idx <= 4'h0;
			bit_cnt <= 12'h000;
		end else begin
			unique case (link_st)
				LK_IDLE: begin
					if (link_go) begin
						sent    <= 1'b1;
						link_st <= LK_SEND;
						frame   <= {1'b1, 6'b00_0000, fault_o, 1'b1, 1'b0};
						bit_idx <= 4'h0;
						bit_cnt <= 12'h000;
					end
				end
				LK_SEND: begin
					if (bit_cnt != 12'(LINK_BIT_CYC - 1)) begin
						bit_cnt <= bit_cnt + 12'h001;
					end else begin
						bit_cnt <= 12'h000;
						frame   <= {1'b1, frame[FRAME_W-1:1]};
						if (bit_idx == 4'(FRAME_W - 1)) begin
							link_st <= LK_IDLE;
						end else begin
							bit_idx <= bit_idx + 4'h1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			host_link_pin_o      <= 1'b1;
			host_link_pin_oe_n_o <= 1'b1;
		end else begin
			host_link_pin_o      <= (link_st == LK_SEND) ? frame[0] : 1'b1;
			host_link_pin_oe_n_o <= (link_st != LK_SEND);
		end
	end

	// ****************************************************
	// interrupt status, mask and output
	// ****************************************************
	assign irq_ev[IRQ_FAULT] = boot_seen && det_en && fault_event_i
		&& !fault_o;
	assign irq_ev[IRQ_WAKE]  = asleep_o && wake;
	assign irq_ev[IRQ_READY] = en_filt && boot_ready_i && !boot_seen;
	assign irq_ev[IRQ_RACE]  = |race;
	assign irq_ev[IRQ_SENT]  = (link_st == LK_SEND)
		&& (bit_idx == 4'(FRAME_W - 1))
		&& (bit_cnt == 12'(LINK_BIT_CYC - 1));

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat <= '0;
		end else if (rd_take && (s_axi_araddr_i == ADDR_IRQ_ST)) begin
			irq_stat <= irq_ev;
		end else begin
			irq_stat <= irq_stat | irq_ev;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// ****************************************************
	// axi4-lite write side
	// ****************************************************
	assign do_wr = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
			aw_addr         <= '0;
			w_data          <= '0;
			w_strb          <= '0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				s_axi_awready_o <= 1'b0;
				aw_addr         <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				s_axi_wready_o <= 1'b0;
				w_data         <= s_axi_wdata_i;
				w_strb         <= s_axi_wstrb_i;
			end
			if (do_wr) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (aw_addr == ADDR_CTRL
					|| aw_addr == ADDR_STATUS
					|| aw_addr == ADDR_IRQ_ST
					|| aw_addr == ADDR_IRQ_MSK) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			dead     <= DEAD_RST;
			det_en   <= 1'b0;
			irq_mask <= '0;
		end else if (do_wr) begin
			if (aw_addr == ADDR_CTRL && w_strb[0]) begin
				dead <= w_data[7:0];
			end
			if (aw_addr == ADDR_CTRL && w_strb[1]) begin
				det_en <= w_data[DET_EN_BIT];
			end
			if (aw_addr == ADDR_IRQ_MSK && w_strb[0]) begin
				irq_mask <= w_data[IRQ_W-1:0];
			end
		end
	end

	// ****************************************************
	// axi4-lite read side
	// ****************************************************
	assign rd_take = s_axi_arvalid_i && s_axi_arready_o;

	always_comb begin
		status           = '0;
		status[ST_FAULT] = fault_o;
		status[ST_ARMED] = boot_seen;
		status[ST_SLEEP] = asleep_o;
		status[ST_RACE]  = |race;
		status[ST_SENT]  = sent;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= RESP_OKAY;
			unique case (s_axi_araddr_i)
				ADDR_CTRL: begin
					s_axi_rdata_o <= {22'h0, 1'b0, det_en, dead};
				end
				ADDR_STATUS: begin
					s_axi_rdata_o <= {27'h0, status};
				end
				ADDR_IRQ_ST: begin
					s_axi_rdata_o <= {27'h0, irq_stat};
				end
				ADDR_IRQ_MSK: begin
					s_axi_rdata_o <= {27'h0, irq_mask};
				end
				default: begin
					s_axi_rdata_o <= '0;
					s_axi_rresp_o <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end
endmodule : gdc_top

// *** testbench/gdc_monitor.sv ***
// checker of pin behaviour of the gate driver control block
// assumes a bind onto gdc_top with one clock domain
`timescale 1ns/1ns
module gdc_monitor
	import gdc_pkg::*;
(
	// clock and reset
	input wire logic       mclk_i,
	input wire logic       rst_i,
	// driver pins
	input wire logic       enable_i,
	input wire logic [2:0] pwm_hi_i,
	input wire logic       fault_event_i,
	input wire logic       lin_activity_i,
	input wire logic [2:0] gate_hi_o,
	input wire logic [2:0] gate_lo_o,
	input wire logic       fault_o,
	input wire logic       asleep_o,
	// link pin
	input wire logic       host_link_pin_oe_n_o
);
	// ********************
	// helper counters
	// ********************
	logic [15:0] low_cnt;
	logic [15:0] oe_cnt;
	logic        sent;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			low_cnt <= '0;
		else if (enable_i)
			low_cnt <= '0;
		else if (low_cnt != 16'hffff)
			low_cnt <= low_cnt + 16'h0001;
	end
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			oe_cnt <= '0;
			sent   <= 1'b0;
		end else if (host_link_pin_oe_n_o) begin
			oe_cnt <= '0;
		end else begin
			oe_cnt <= oe_cnt + 16'h0001;
			sent   <= 1'b1;
		end
	end
	// ********************
	// assertions
	// ********************
	default clocking dc @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	AST_GATE_FALL: assert property (!pwm_hi_i[0] ##1 !pwm_hi_i[0]
		|=> !gate_hi_o[0]) else $error("gate stayed high after pwm low");
	AST_FAULT_CAUSE: assert property ($rose(fault_o)
		|-> $past(fault_event_i)) else $error("fault without event");
	AST_FAULT_GATES: assert property (fault_o
		|=> (gate_hi_o | gate_lo_o) == 3'h0) else $error("gate on in fault");
	AST_FAULT_HOLD: assert property (fault_o && enable_i
		|=> fault_o) else $error("fault lost with enable high");
	AST_FAULT_CLEAR: assert property ($fell(fault_o)
		|-> low_cnt == FILT_CYC) else $error("fault cleared early");
	AST_FRAME_LEN: assert property ($rose(host_link_pin_oe_n_o)
		|-> oe_cnt == FRAME_W * LINK_BIT_CYC) else $error("frame length");
	AST_ONE_RPT: assert property ($fell(host_link_pin_oe_n_o)
		|-> !sent) else $error("report repeated");
	AST_WAKE: assert property (asleep_o &&
		($changed(enable_i) || $changed(lin_activity_i))
		|-> ##[1:2] !asleep_o) else $error("no wake on activity");
endmodule : gdc_monitor

// *** testbench/gdc_host_model.sv ***
// host model: enable, pwm, bootstrap ready and the shared link line
// assumes its tasks are called just after a rising edge of mclk_i
`timescale 1ns/1ns
module gdc_host_model
	import gdc_pkg::*;
#(
	parameter int BOOT_CYC = 12500
)
(
	// clock
	input  wire logic       mclk_i,
	// device side of the link pin
	input  wire logic       dev_link_i,
	input  wire logic       dev_link_oe_n_i,
	// pins towards the device
	output logic            enable_o,
	output logic [2:0]      pwm_hi_o,
	output logic [2:0]      pwm_lo_o,
	output logic            boot_ready_o,
	output logic            link_o
);
	// ********************
	// host behaviour
	// ********************
	logic host_drv;
	// pulled-up line, low while either side pulls it low
	assign link_o = host_drv & (dev_link_oe_n_i | dev_link_i);
	initial begin
		enable_o     = 1'b0;
		pwm_hi_o     = 3'h0;
		pwm_lo_o     = 3'h0;
		boot_ready_o = 1'b0;
		host_drv     = 1'b1;
	end
	task automatic en(input logic v, input int n);
		enable_o <= v;
		repeat (n) @(posedge mclk_i);
	endtask : en
	task automatic power_up();
		en(1'b1, BOOT_CYC);
		boot_ready_o <= 1'b1;
		@(posedge mclk_i);
	endtask : power_up
	task automatic pulse(input logic [5:0] m, input int w);
		{pwm_hi_o, pwm_lo_o} <= m;
		repeat (w) @(posedge mclk_i);
		{pwm_hi_o, pwm_lo_o} <= 6'h00;
		repeat (40) @(posedge mclk_i);
	endtask : pulse
	task automatic link_low(input int n);
		host_drv <= 1'b0;
		repeat (n) @(posedge mclk_i);
		host_drv <= 1'b1;
	endtask : link_low
endmodule : gdc_host_model

// *** testbench/testbench.sv ***
// self-checking bench of the gate driver control block
// assumes gdc_top, the host model and the checker are compiled first
`timescale 1ns/1ns
module testbench
	import gdc_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	logic        enable, boot, fault_ev, lin, lpo, loe, lwire;
	logic        fault, asleep, irq;
	logic [2:0]  pwm_hi, pwm_lo, gate_hi, gate_lo;
	logic [5:0]  msk;
	int          fail_count, checked, cyc, hi_cnt, i, w;
	int          seed = 32'hee2e_c480;
	gdc_top uut (
		.mclk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.enable_i(enable), .pwm_hi_i(pwm_hi), .pwm_lo_i(pwm_lo),
		.boot_ready_i(boot), .fault_event_i(fault_ev), .lin_activity_i(lin),
		.gate_hi_o(gate_hi), .gate_lo_o(gate_lo), .fault_o(fault),
		.asleep_o(asleep), .host_link_pin_i(lwire), .host_link_pin_o(lpo),
		.host_link_pin_oe_n_o(loe), .irq_o(irq)
	);
	gdc_host_model host (
		.mclk_i(clk), .dev_link_i(lpo), .dev_link_oe_n_i(loe),
		.enable_o(enable), .pwm_hi_o(pwm_hi), .pwm_lo_o(pwm_lo),
		.boot_ready_o(boot), .link_o(lwire)
	);
	// ********************
	// helpers
	// ********************
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fail_count++;
			report_and_stop();
		end
	end
	always @(posedge clk)
		if (|({gate_hi, gate_lo} & msk))
			hi_cnt <= hi_cnt + 1;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	function automatic logic [9:0] exp_frame(input logic flt);
		exp_frame = 10'h200;
		exp_frame[RPT_BROWNOUT_WARNING_FLAG + 1] = 1'b1;
		exp_frame[RPT_FAULT + 1] = flt;
	endfunction : exp_frame
	function automatic int exp_w(input int pw, input int dd);
		return (pw > dd) ? pw - dd : 0;
	endfunction : exp_w
	task automatic frame();
		logic [9:0] s;
		while (loe !== 1'b0)
			@(posedge clk);
		repeat (LINK_BIT_CYC / 2) @(posedge clk);
		for (int k = 0; k < FRAME_W; k++) begin
			s[k] = lwire;
			repeat (LINK_BIT_CYC) @(posedge clk);
		end
		chk(s, exp_frame(1'b0));
	endtask : frame
	task automatic report_and_stop();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	// ********************
	// main sequence
	// ********************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, fault_ev, lin, msk} = '0;
		{fail_count, checked, cyc, hi_cnt} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_CTRL);
		chk(d, {24'h00_0000, DEAD_RST});
		rd(8'h40);
		chk(d, 32'h0000_0000);
		chk(r, RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk(r, RESP_SLVERR);
		host.en(1'b0, 4);
		host.en(1'b1, 4);
		host.en(1'b0, 4);
		frame();
		host.en(1'b1, 20);
		host.link_low(20);
		chk(loe, 1'b1);
		$display("test report done");
		wr(ADDR_CTRL, 32'h0000_0104);
		msk = 6'h3f;
		fault_ev <= 1'b1;
		host.pulse(6'h21, 8);
		fault_ev <= 1'b0;
		chk(hi_cnt, 32'h0000_0000);
		chk(fault, 1'b0);
		host.power_up();
		rd(ADDR_IRQ_ST);
		chk(d, (32'h0000_0001 << IRQ_SENT) | (32'h0000_0001 << IRQ_READY));
		rd(ADDR_STATUS);
		chk(d, (32'h0000_0001 << ST_ARMED) | (32'h0000_0001 << ST_SENT));
		for (i = 0; i < 10; i++) begin
			w = (i == 0) ? 1 : (i == 1) ? 7 : 7 + ($unsigned($random(seed)) % 8);
			msk = 6'h01 << ($unsigned($random(seed)) % 6);
			hi_cnt = 0;
			host.pulse(msk, w);
			chk(hi_cnt, exp_w(w, 4));
		end
		wr(ADDR_IRQ_MSK, 32'h0000_0001 << IRQ_RACE);
		hi_cnt = 0;
		host.pulse(6'h20, 4);
		chk(hi_cnt, 32'h0000_0000);
		chk(irq, 1'b1);
		rd(ADDR_IRQ_ST);
		chk(d, 32'h0000_0001 << IRQ_RACE);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		$display("test dead time done");
		fault_ev <= 1'b1;
		repeat (3) @(posedge clk);
		fault_ev <= 1'b0;
		chk(fault, 1'b1);
		host.en(1'b0, FILT_CYC - 1);
		host.en(1'b1, 4);
		chk(fault, 1'b1);
		host.en(1'b0, FILT_CYC);
		host.en(1'b1, 4);
		chk(fault, 1'b0);
		$display("test fault done");
		wr(ADDR_STATUS, 32'hffff_ffff);
		chk(r, RESP_OKAY);
		wr(ADDR_IRQ_MSK, 32'h0000_0001 << IRQ_WAKE);
		rd(ADDR_IRQ_ST);
		for (i = 0; i < 2; i++) begin
			wr(ADDR_CTRL, 32'h0000_0304);
			repeat (2) @(posedge clk);
			chk({asleep, irq}, 2'b10);
			if (i == 0)
				lin <= ~lin;
			else
				host.en(1'b0, 1);
			repeat (4) @(posedge clk);
			chk({asleep, irq}, 2'b01);
			rd(ADDR_IRQ_ST);
			chk(d, 32'h0000_0001 << IRQ_WAKE);
		end
		rd(ADDR_CTRL);
		chk(d, 32'h0000_0104);
		$display("test sleep done");
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		host.link_low(20);
		frame();
		rd(ADDR_STATUS);
		chk(d, 32'h0000_0001 << ST_SENT);
		$display("test restart done");
		report_and_stop();
	end
endmodule : testbench
bind gdc_top gdc_monitor mon (
	.mclk_i, .rst_i, .enable_i, .pwm_hi_i, .fault_event_i, .lin_activity_i,
	.gate_hi_o, .gate_lo_o, .fault_o, .asleep_o, .host_link_pin_oe_n_o
);
